// >>> tcr_top.sv
// three 16-bit programmable down-counters behind a classic wishbone slave
// Operation
// (R1) three separate 16-bit counters, each with own mode and binary/decimal choice
// (R2) offsets 0..2 are counter data ports, offset 3 is write-only control
// (R3) host writes a count as low byte then high byte
// (R4) new count enters counter only on next count pulse with gate high; modes 1 and 5 load it on the first pulse after a gate rise instead
// (R5) latched status byte is read instead of count data
// (R6) host writes control word before initial count
// (R7) host loads count in the byte format chosen by control word
// (R8) control and data accesses may interleave freely
// (R9) control word resets counter logic and sets mode's initial output level
// (R10) six modes: terminal count, one-shot, rate, square, soft strobe, hard strobe
// (R11) control byte: select 7:6, format 5:4, mode 3:1, decimal bit 0
// (R12) select 00,01,10 picks counter; 11 means read-back command
// (R13) control writes can latch count and/or status for later reads
// (R14) read-back latches several counters in one write
// (R15) counter-latch captures one count without disturbing counting
// (R16) format 00 latch, 01 low only, 10 high only, 11 low then high
// (R17) decimal bit clear counts binary, set counts four decades
// (R18) read-back: active-low count/status bits 5,4, counter picks bits 3:1
// (R19) status returned once then released: out, null count, configuration
// (R20) 2-bit offset, 8-bit data, single-cycle accesses, synchronised count clocks
`default_nettype none
`timescale 1ns/100ps
module tcr_top #(
    parameter int NUM_CH = 3,
    parameter int CNT_W  = 16
) (
    // system
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [1:0]        wb_adr_i,
    input  wire logic              wb_sel_i,
    input  wire logic [7:0]        wb_dat_i,
    output logic      [7:0]        wb_dat_o,
    output logic                   wb_ack_o,
    // counter pins
    input  wire logic [NUM_CH-1:0] ctr_clk_i,
    input  wire logic [NUM_CH-1:0] ctr_gate_i,
    output logic      [NUM_CH-1:0] ctr_out_o
);
    logic       ack_reg;
    logic [7:0] dat_reg;
    logic [7:0] rbyte_w [NUM_CH];

    // one access per request; ack gates a repeat
    wire acc_w     = wb_cyc_i & wb_stb_i & ~ack_reg & ce_i; // (R20)
    wire wr_w      = acc_w & wb_we_i & wb_sel_i;
    wire rd_w      = acc_w & ~wb_we_i;
    wire ctrl_wr_w = wr_w & (wb_adr_i == tcr_pkg::OFS_CTRL); // (R2)
    wire [1:0] cw_sel_w = wb_dat_i[tcr_pkg::SEL_LSB +: 2]; // (R11)
    wire [1:0] cw_fmt_w = wb_dat_i[tcr_pkg::FMT_LSB +: 2];
    wire rb_w      = ctrl_wr_w & (cw_sel_w == tcr_pkg::SEL_READBACK); // (R12)

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            dat_reg <= tcr_pkg::RST_BYTE;
        end
        else if (ce_i)
        begin
            ack_reg <= acc_w;
            if (rd_w)
            begin
                // control port is write-only and reads as zero
                dat_reg <= (wb_adr_i == tcr_pkg::OFS_CTRL) ? tcr_pkg::UNMAPPED_RD
                                                           : rbyte_w[wb_adr_i]; // (R2)
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    for (genvar i = 0; i < NUM_CH; i++) // (R1)
    begin : g_ch
        logic                    tick_w;
        logic                    gate_w;
        logic                    grise_w;
        logic [5:0]              cfg_reg;
        logic [CNT_W-1:0]        cr_reg;
        logic [CNT_W-1:0]        ce_reg;
        logic [CNT_W-1:0]        ol_reg;
        logic                    olv_reg;
        logic [7:0]              st_reg;
        logic                    stv_reg;
        logic                    out_reg;
        logic                    null_reg;
        logic                    ldp_reg;
        logic                    have_reg;
        logic                    trig_reg;
        logic                    armed_reg;
        tcr_pkg::tcr_phase_t     wph_reg;
        tcr_pkg::tcr_phase_t     rph_reg;

        tcr_sync_edge u_sync (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .ce_i        (ce_i),
            .cnt_clk_i   (ctr_clk_i[i]),
            .gate_i      (ctr_gate_i[i]),
            .tick_o      (tick_w),
            .gate_o      (gate_w),
            .gate_rise_o (grise_w)
        ); // (R20)

        wire [2:0] mode_w = tcr_pkg::tcr_mode(cfg_reg[tcr_pkg::MODE_LSB +: 3]); // (R10)
        wire       bcd_w  = cfg_reg[tcr_pkg::DEC_BIT]; // (R17)
        wire [1:0] fmt_w  = cfg_reg[tcr_pkg::FMT_LSB +: 2];
        wire [CNT_W-1:0] dec1_w = tcr_pkg::tcr_dec(ce_reg, bcd_w, 2'h1); // (R17)
        wire [CNT_W-1:0] dec2_w = tcr_pkg::tcr_dec(ce_reg, bcd_w, 2'h2);
        wire hit_w   = ctrl_wr_w & (cw_sel_w == 2'(i)); // (R8)
        wire cfg_w   = hit_w & (cw_fmt_w != tcr_pkg::FMT_LATCH); // (R16)
        wire pick_w  = rb_w & wb_dat_i[tcr_pkg::RB_PICK + i]; // (R18)
        wire lat_c_w = (hit_w & (cw_fmt_w == tcr_pkg::FMT_LATCH))
                     | (pick_w & ~wb_dat_i[tcr_pkg::RB_NCOUNT]); // (R14)
        wire lat_s_w = pick_w & ~wb_dat_i[tcr_pkg::RB_NSTAT]; // (R13)
        wire dwr_w   = wr_w & (wb_adr_i == 2'(i));
        wire drd_w   = rd_w & (wb_adr_i == 2'(i));
        wire hi_w    = (fmt_w == tcr_pkg::FMT_HI)
                     | ((fmt_w == tcr_pkg::FMT_BOTH) & (rph_reg == tcr_pkg::PH_HIGH)); // (R16)
        wire last_w  = (fmt_w != tcr_pkg::FMT_BOTH) | (rph_reg == tcr_pkg::PH_HIGH);
        wire done_w  = (fmt_w != tcr_pkg::FMT_BOTH) | (wph_reg == tcr_pkg::PH_HIGH);
        wire [CNT_W-1:0] src_w = olv_reg ? ol_reg : ce_reg;
        wire trig_md_w = (mode_w == tcr_pkg::MODE_ONESHOT) | (mode_w == tcr_pkg::MODE_HWSTB);
        wire per_md_w  = (mode_w == tcr_pkg::MODE_RATE) | (mode_w == tcr_pkg::MODE_SQUARE);

        // status overrides count data until it is read
        assign rbyte_w[i] = stv_reg ? st_reg
                          : (hi_w ? src_w[15:8] : src_w[7:0]); // (R5)
        assign ctr_out_o[i] = out_reg;

        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                cfg_reg   <= tcr_pkg::RST_CFG;
                cr_reg    <= tcr_pkg::RST_COUNT;
                ce_reg    <= tcr_pkg::RST_COUNT;
                ol_reg    <= tcr_pkg::RST_COUNT;
                olv_reg   <= 1'b0;
                st_reg    <= tcr_pkg::RST_BYTE;
                stv_reg   <= 1'b0;
                out_reg   <= 1'b0;
                null_reg  <= 1'b1;
                ldp_reg   <= 1'b0;
                have_reg  <= 1'b0;
                trig_reg  <= 1'b0;
                armed_reg <= 1'b0;
                wph_reg   <= tcr_pkg::PH_LOW;
                rph_reg   <= tcr_pkg::PH_LOW;
            end
            else if (ce_i)
            begin
                // counting element, one step per count clock pulse
                if (tick_w)
                begin
                    case (mode_w)
                        tcr_pkg::MODE_TC, tcr_pkg::MODE_SWSTB:
                        begin
                            if (ldp_reg & gate_w)
                            begin
                                ce_reg    <= cr_reg; // (R4)
                                ldp_reg   <= 1'b0;
                                null_reg  <= 1'b0;
                                armed_reg <= 1'b1;
                            end
                            else if (gate_w | (mode_w == tcr_pkg::MODE_SWSTB))
                            begin
                                ce_reg <= dec1_w;
                                if (~out_reg & (mode_w == tcr_pkg::MODE_SWSTB))
                                begin
                                    out_reg <= 1'b1;
                                end
                                else if (armed_reg & (dec1_w == '0) & gate_w)
                                begin
                                    // mode 0 rises and holds; mode 4 pulses low
                                    out_reg   <= (mode_w == tcr_pkg::MODE_TC); // (R10)
                                    armed_reg <= 1'b0;
                                end
                            end
                        end
                        tcr_pkg::MODE_ONESHOT, tcr_pkg::MODE_HWSTB:
                        begin
                            if (trig_reg)
                            begin
                                ce_reg    <= cr_reg; // (R4)
                                trig_reg  <= 1'b0;
                                null_reg  <= 1'b0;
                                armed_reg <= 1'b1;
                                out_reg   <= (mode_w == tcr_pkg::MODE_HWSTB);
                            end
                            else
                            begin
                                ce_reg <= dec1_w;
                                if (~out_reg & (mode_w == tcr_pkg::MODE_HWSTB))
                                begin
                                    out_reg <= 1'b1;
                                end
                                else if (armed_reg & (dec1_w == '0))
                                begin
                                    out_reg   <= (mode_w == tcr_pkg::MODE_ONESHOT); // (R10)
                                    armed_reg <= 1'b0;
                                end
                            end
                        end
                        tcr_pkg::MODE_RATE:
                        begin
                            if (gate_w)
                            begin
                                if (ldp_reg | trig_reg | (ce_reg == 16'h0001))
                                begin
                                    ce_reg   <= cr_reg; // (R4)
                                    ldp_reg  <= 1'b0;
                                    trig_reg <= 1'b0;
                                    null_reg <= 1'b0;
                                    out_reg  <= 1'b1;
                                end
                                else
                                begin
                                    ce_reg  <= dec1_w;
                                    out_reg <= (dec1_w != 16'h0001); // (R10)
                                end
                            end
                        end
                        tcr_pkg::MODE_SQUARE:
                        begin
                            if (gate_w)
                            begin
                                if (ldp_reg | trig_reg | (ce_reg <= 16'h0002))
                                begin
                                    ce_reg   <= cr_reg; // (R4)
                                    ldp_reg  <= 1'b0;
                                    trig_reg <= 1'b0;
                                    null_reg <= 1'b0;
                                    out_reg  <= (ldp_reg | trig_reg) | ~out_reg; // (R10)
                                end
                                else
                                begin
                                    ce_reg <= dec2_w;
                                end
                            end
                        end
                        default:
                        begin
                            ce_reg <= ce_reg;
                        end
                    endcase
                end
                // gate low holds periodic outputs high
                if (per_md_w & ~gate_w)
                begin
                    out_reg <= 1'b1;
                end
                // gate edge triggers or restarts
                if (grise_w & ((trig_md_w & have_reg) | per_md_w))
                begin
                    trig_reg <= 1'b1;
                end
                // latch commands leave counting untouched
                if (lat_c_w & ~olv_reg)
                begin
                    ol_reg  <= ce_reg; // (R15)
                    olv_reg <= 1'b1; // (R18)
                end
                if (lat_s_w & ~stv_reg)
                begin
                    st_reg  <= {out_reg, null_reg, cfg_reg}; // (R19)
                    stv_reg <= 1'b1;
                end
                // data port read, status first then count bytes
                if (drd_w)
                begin
                    if (stv_reg)
                    begin
                        stv_reg <= 1'b0; // (R19)
                    end
                    else
                    begin
                        if (olv_reg & last_w)
                        begin
                            olv_reg <= 1'b0; // (R13)
                        end
                        if (fmt_w == tcr_pkg::FMT_BOTH)
                        begin
                            rph_reg <= last_w ? tcr_pkg::PH_LOW : tcr_pkg::PH_HIGH;
                        end
                    end
                end
                // data port write, byte assembly per format
                if (dwr_w)
                begin
                    case (fmt_w)
                        tcr_pkg::FMT_LO:   cr_reg <= {8'h00, wb_dat_i}; // (R16)
                        tcr_pkg::FMT_HI:   cr_reg <= {wb_dat_i, 8'h00};
                        tcr_pkg::FMT_BOTH:
                        begin
                            if (wph_reg == tcr_pkg::PH_LOW)
                            begin
                                cr_reg[7:0] <= wb_dat_i; // (R3)
                                wph_reg     <= tcr_pkg::PH_HIGH;
                            end
                            else
                            begin
                                cr_reg[15:8] <= wb_dat_i;
                                wph_reg      <= tcr_pkg::PH_LOW;
                            end
                        end
                        default:           cr_reg <= cr_reg;
                    endcase
                    if (done_w)
                    begin
                        null_reg <= 1'b1;
                        have_reg <= 1'b1;
                        ldp_reg  <= ~trig_md_w; // (R4)
                        if (mode_w == tcr_pkg::MODE_TC)
                        begin
                            out_reg   <= 1'b0;
                            armed_reg <= 1'b0;
                        end
                    end
                end
                // control word wins over everything for this counter
                if (cfg_w)
                begin
                    cfg_reg   <= wb_dat_i[tcr_pkg::CFG_W-1:0]; // (R11)
                    out_reg   <= (tcr_pkg::tcr_mode(wb_dat_i[tcr_pkg::MODE_LSB +: 3])
                                  != tcr_pkg::MODE_TC); // (R9)
                    null_reg  <= 1'b1;
                    ldp_reg   <= 1'b0;
                    have_reg  <= 1'b0;
                    trig_reg  <= 1'b0;
                    armed_reg <= 1'b0;
                    wph_reg   <= tcr_pkg::PH_LOW; // (R9)
                    rph_reg   <= tcr_pkg::PH_LOW;
                end
            end
        end
    end
endmodule // tcr_top
`default_nettype wire

// >>> tcr_pkg.sv
// constants, field layout and arithmetic helpers for the triple counter block
`default_nettype none
package tcr_pkg;
    // register offsets
    localparam logic [1:0] OFS_CTR0 = 2'h0;
    localparam logic [1:0] OFS_CTR1 = 2'h1;
    localparam logic [1:0] OFS_CTR2 = 2'h2;
    localparam logic [1:0] OFS_CTRL = 2'h3;

    // control byte fields
    localparam int SEL_LSB   = 6;
    localparam int FMT_LSB   = 4;
    localparam int MODE_LSB  = 1;
    localparam int DEC_BIT   = 0;
    localparam int CFG_W     = 6;
    // read-back byte fields
    localparam int RB_NCOUNT = 5;
    localparam int RB_NSTAT  = 4;
    localparam int RB_PICK   = 1;

    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] FMT_LATCH    = 2'h0;
    localparam logic [1:0] FMT_LO       = 2'h1;
    localparam logic [1:0] FMT_HI       = 2'h2;
    localparam logic [1:0] FMT_BOTH     = 2'h3;

    localparam logic [2:0] MODE_TC     = 3'h0;
    localparam logic [2:0] MODE_ONESHOT = 3'h1;
    localparam logic [2:0] MODE_RATE   = 3'h2;
    localparam logic [2:0] MODE_SQUARE = 3'h3;
    localparam logic [2:0] MODE_SWSTB  = 3'h4;
    localparam logic [2:0] MODE_HWSTB  = 3'h5;

    // reset values
    localparam logic [5:0]  RST_CFG   = 6'h30;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [7:0]  UNMAPPED_RD = 8'h00;

    // byte pointer for two-byte transfers
    typedef enum logic [1:0] {
        PH_LOW  = 2'b01,
        PH_HIGH = 2'b10
    } tcr_phase_t;

    // modes 2 and 3 ignore the top mode bit
    function automatic logic [2:0] tcr_mode(input logic [2:0] m);
        tcr_mode = m[1] ? {1'b0, m[1:0]} : m;
    endfunction

    // down count by step, binary or four decades
    function automatic logic [15:0] tcr_dec(input logic [15:0] v, input logic bcd,
                                            input logic [1:0] step);
        logic [15:0] r;
        logic [4:0]  dg;
        logic [3:0]  b;
        r = v - {14'h0000, step};
        b = {2'b00, step};
        if (bcd)
        begin
            for (int i = 0; i < 4; i++)
            begin
                dg = {1'b0, v[i*4 +: 4]} - {1'b0, b};
                if (dg[4])
                begin
                    dg = dg + 5'h0A;
                    b  = 4'h1;
                end
                else
                begin
                    b = 4'h0;
                end
                r[i*4 +: 4] = dg[3:0];
            end
        end
        tcr_dec = r;
    endfunction
endpackage
`default_nettype wire

// >>> tcr_sync_edge.sv
// count clock and gate synchroniser with edge detection
`default_nettype none
`timescale 1ns/100ps
module tcr_sync_edge (
    // system
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // pins
    input  wire logic cnt_clk_i,
    input  wire logic gate_i,
    // synchronised view
    output logic      tick_o,
    output logic      gate_o,
    output logic      gate_rise_o
);
    logic c_meta_reg;
    logic c_sync_reg;
    logic c_prev_reg;
    logic g_meta_reg;
    logic g_sync_reg;
    logic g_prev_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            c_meta_reg <= 1'b0;
            c_sync_reg <= 1'b0;
            c_prev_reg <= 1'b0;
            g_meta_reg <= 1'b0;
            g_sync_reg <= 1'b0;
            g_prev_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            c_meta_reg <= cnt_clk_i;
            c_sync_reg <= c_meta_reg;
            c_prev_reg <= c_sync_reg;
            g_meta_reg <= gate_i;
            g_sync_reg <= g_meta_reg;
            g_prev_reg <= g_sync_reg;
        end
    end

    // counting happens on the falling edge of the count clock
    assign tick_o      = ce_i & c_prev_reg & ~c_sync_reg;
    assign gate_o      = g_sync_reg;
    assign gate_rise_o = ce_i & g_sync_reg & ~g_prev_reg;
endmodule // tcr_sync_edge
`default_nettype wire

// >>> tcr_top_chk.sv
// assertion checker for the triple counter wishbone slave
`timescale 1ns/100ps
`default_nettype none
module tcr_top_chk #(
    parameter int NUM_CH = 3,
    parameter int CNT_W  = 16
) (
    // system
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              ce_i,
    // wishbone
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [1:0]        wb_adr_i,
    input wire logic              wb_sel_i,
    input wire logic [7:0]        wb_dat_i,
    input wire logic [7:0]        wb_dat_o,
    input wire logic              wb_ack_o,
    // counter pins
    input wire logic [NUM_CH-1:0] ctr_clk_i,
    input wire logic [NUM_CH-1:0] ctr_gate_i,
    input wire logic [NUM_CH-1:0] ctr_out_o
);
    wire req_take = wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o;
    wire ctl_wr   = req_take && wb_we_i && wb_sel_i && wb_adr_i == tcr_pkg::OFS_CTRL;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows: assert property (req_take |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req_take))
        else $error("ack without a request");
    // one-cycle reset would show its own clearing as a change
    a_dat_hold: assert property (!$stable(wb_dat_o) && !$past(rst_i) |-> $rose(wb_ack_o) && !$past(wb_we_i))
        else $error("read data moved outside a read");
    a_ctl_rd_zero: assert property (req_take && !wb_we_i && wb_adr_i == tcr_pkg::OFS_CTRL |=> wb_dat_o == tcr_pkg::UNMAPPED_RD)
        else $error("control port read not zero");
    a_mode0_low: assert property (ctl_wr && wb_dat_i[7:6] == 2'h0 && wb_dat_i[5:4] != 2'h0
                                  && wb_dat_i[3:1] == 3'h0 |-> ##[1:3] !ctr_out_o[0])
        else $error("mode 0 output not low after control");
    a_other_high: assert property (ctl_wr && wb_dat_i[7:6] == 2'h1 && wb_dat_i[5:4] != 2'h0
                                   && wb_dat_i[3:1] != 3'h0 |-> ##[1:3] ctr_out_o[1])
        else $error("output not high after control");
    a_ce_freeze: assert property (!ce_i |=> $stable(wb_ack_o) && $stable(wb_dat_o) && $stable(ctr_out_o))
        else $error("state moved with clock enable low");
endmodule // tcr_top_chk
bind tcr_top tcr_top_chk #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ctr_clk_i(ctr_clk_i),
    .ctr_gate_i(ctr_gate_i), .ctr_out_o(ctr_out_o)
);
`default_nettype wire

// >>> tcr_pin_drv.sv
// count clock source standing in for the counter pins
`timescale 1ns/100ps
`default_nettype none
module tcr_pin_drv (
    // system
    input  wire logic       clk_i,
    // count clocks
    output var  logic [2:0] pin_clk_o
);
    initial pin_clk_o = 3'h0;
    // clock rests low between pulses, each level well over two periods
    task pulse(input int ch);
        @(posedge clk_i);
        pin_clk_o[ch] <= 1'b1;
        repeat (3) @(posedge clk_i);
        pin_clk_o[ch] <= 1'b0;
        // room for the sync chain and the count update
        repeat (6) @(posedge clk_i);
    endtask
endmodule // tcr_pin_drv
`default_nettype wire

// >>> tcr_top_bench.sv
// self-checking bench for the triple counter block
`timescale 1ns/100ps
`default_nettype none
module tcr_top_bench;
    logic       clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_ack_o;
    logic [1:0] wb_adr_i;
    logic [7:0] wb_dat_i, wb_dat_o;
    logic [2:0] ctr_clk_i, ctr_gate_i, ctr_out_o;
    logic [7:0] q[$];
    logic [15:0] v;
    logic       b;
    int         num_errors, n_checks, cycles;

    tcr_top i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .ctr_clk_i(ctr_clk_i), .ctr_gate_i(ctr_gate_i),
        .ctr_out_o(ctr_out_o)
    );
    tcr_pin_drv i_pin (.clk_i(clk_i), .pin_clk_o(ctr_clk_i));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // request held until ack is sampled, then cyc and stb drop
    task automatic bus(input logic [1:0] a, input logic w, input logic [7:0] d, input logic s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 1'b1);
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        q.push_back(e);
        // reads ignore sel, so it is left random
        bus(a, 1'b0, 8'($urandom), 1'($urandom));
    endtask

    task automatic rd2(input logic [1:0] a, input logic [15:0] e);
        rd(a, e[7:0]);
        rd(a, e[15:8]);
    endtask

    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q.size() > 0)
            check("rd_data", {8'h00, wb_dat_o}, {8'h00, q.pop_front()});
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            finish_test();
        end
    end

    initial
    begin
        {rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} = 6'b110000;
        {wb_adr_i, wb_dat_i, ctr_gate_i} = 13'h0000;
        {num_errors, n_checks, cycles} = '0;
        void'($urandom(32'h94a5));
        v = 16'h0100 + 16'($urandom % 32'h7F00);
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(tcr_pkg::OFS_CTRL, tcr_pkg::UNMAPPED_RD);
        wr(tcr_pkg::OFS_CTRL, 8'h30);
        wr(tcr_pkg::OFS_CTR0, v[7:0]);
        wr(tcr_pkg::OFS_CTR0, v[15:8]);
        // gate low: the pulse must not load the new count
        i_pin.pulse(0);
        wr(tcr_pkg::OFS_CTRL, 8'h00);
        rd2(tcr_pkg::OFS_CTR0, tcr_pkg::RST_COUNT);
        ctr_gate_i <= 3'h7;
        i_pin.pulse(0);
        wr(tcr_pkg::OFS_CTRL, 8'h00);
        i_pin.pulse(0);
        rd2(tcr_pkg::OFS_CTR0, v);
        wr(tcr_pkg::OFS_CTRL, 8'h71);
        // sel low: acked but must not move the byte pointer
        bus(tcr_pkg::OFS_CTR1, 1'b1, 8'hFF, 1'b0);
        wr(tcr_pkg::OFS_CTR1, 8'h00);
        wr(tcr_pkg::OFS_CTR1, 8'h10);
        i_pin.pulse(1);
        i_pin.pulse(1);
        wr(tcr_pkg::OFS_CTRL, 8'h40);
        rd2(tcr_pkg::OFS_CTR1, 16'h0999);
        // one read-back latches two counts at once
        wr(tcr_pkg::OFS_CTRL, 8'hD6);
        i_pin.pulse(0);
        rd2(tcr_pkg::OFS_CTR0, v - 16'h0001);
        rd2(tcr_pkg::OFS_CTR1, 16'h0999);
        @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        ce_i <= 1'b1;
        for (int m = 0; m < 6; m++)
        begin
            b = 1'($urandom);
            wr(tcr_pkg::OFS_CTRL, {2'(m % 3), 2'b11, 3'(m), b});
            wr(tcr_pkg::OFS_CTRL, 8'hE0 | (8'h02 << (m % 3)));
            rd(2'(m % 3), {m != 0, 1'b1, 2'b11, 3'(m), b});
        end
        repeat (3) @(posedge clk_i);
        check("out_pins", {13'h0000, ctr_out_o}, 16'h0007);
        check("queue_left", 16'(q.size()), 16'h0000);
        finish_test();
    end
endmodule // tcr_top_bench
`default_nettype wire
